// ### rtl/lpw_exec.sv
// Load, OR and port-write execution sequencer with its register set
`timescale 1ns/10ps
`default_nettype none
module lpw_exec
    import lpw_pkg::*;
(
    input  wire logic       sys_clk,      // 200 MHz
    input  wire logic       rst_n,        // Sync reset
    input  wire logic [7:0] mem_rdata,    // Memory data bus
    output var  lpw_mem_bus_type  mem_bus,   // Address, read strobe
    output var  lpw_port_bus_type port_bus,  // Port address, data, strobe
    output var  logic [7:0] accumulator,  // Primary register
    output var  logic [7:0] secondary,    // Secondary register
    output var  logic [7:0] instruction_pointer,
    output var  logic       instr_done,   // Pulse after last cycle
    output var  logic       instr_unknown // Pulse: opcode not handled
);

////////////////////////////////////////////////////////////////////
// Registers
lpw_state_type state_q;             // Current step
lpw_state_type state_d;             // Next step
logic [7:0]    ip_q;                // Instruction pointer
logic [7:0]    ar_q;                // Address output register
logic [7:0]    dr_q;                // Data buffer register
logic [7:0]    opl_q;               // Operand address latch
logic [7:0]    ir_q;                // Decoded opcode
logic [7:0]    acc_q;               // Accumulator
logic [7:0]    sec_q;               // Secondary register
logic          memory_read_strobe_q;              // Memory read strobe
logic          iow_q;               // Port write strobe
logic [7:0]    pdata_q;             // Port data out
logic          poe_q;               // Port data drive
logic          done_q;              // Completion pulse
logic          unk_q;               // Unknown opcode pulse

////////////////////////////////////////////////////////////////////
// Opcode classes, decoded from the fetched byte
logic [7:0] op_f;                   // Opcode under decode
logic       f_imm;                  // Immediate second byte
logic       f_dir;                  // Direct second byte
logic       f_ind;                  // Operand at secondary
logic       f_port;                 // Port write
logic       f_known;                // Handled here

// Decode uses the buffer while in the third fetch cycle
always_comb begin
    op_f    = (state_q == ST_FETCH3) ? dr_q : ir_q;
    f_imm   = (op_f == OP_LDA_IMM) || (op_f == OP_LDR_IMM) || (op_f == OP_OR_IMM);
    f_dir   = (op_f == OP_LDR_DIR) || (op_f == OP_OR_DIR) || (op_f == OP_OUT_DIR);
    f_ind   = (op_f == OP_LDA_IND) || (op_f == OP_LDR_IND) || (op_f == OP_OR_IND)
              || (op_f == OP_OUT_IND);
    f_port  = (op_f == OP_OUT_DIR) || (op_f == OP_OUT_IND);
    f_known = f_imm || f_dir || f_ind || (op_f == OP_LDR_ACC) || (op_f == OP_LDR_SEC)
              || (op_f == OP_OR_ACC) || (op_f == OP_OR_SEC);
end

////////////////////////////////////////////////////////////////////
// Step sequencer
always_comb begin
    case (state_q)
        ST_START:  state_d = ST_FETCH1;
        ST_FETCH1: state_d = ST_FETCH2;             // RULE1
        ST_FETCH2: state_d = ST_FETCH3;             // RULE1
        ST_FETCH3: begin
            if (f_imm || f_dir) begin
                state_d = ST_B2_ADR;                // RULE21
            end else if (f_ind) begin
                state_d = ST_OPL;
            end else begin
                state_d = ST_EXEC;                  // RULE8
            end
        end
        ST_B2_ADR: state_d = ST_B2_RD;              // RULE2
        ST_B2_RD:  state_d = f_dir ? ST_OPL : ST_EXEC;
        ST_OPL:    state_d = f_port ? ST_WR_SET : ST_RD_ADR; // RULE19
        ST_RD_ADR: state_d = ST_RD_DAT;             // RULE3
        ST_RD_DAT: state_d = ST_EXEC;
        ST_WR_SET: state_d = ST_WR_STB;             // RULE18
        ST_WR_STB: state_d = ST_WR_HLD;             // RULE18
        ST_WR_HLD: state_d = ST_FETCH1;             // RULE22
        ST_EXEC:   state_d = ST_FETCH1;             // RULE22
        default:   state_d = ST_START;
    endcase
end

// State register
always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
        state_q <= ST_START;
    end else begin
        state_q <= state_d;
    end
end

////////////////////////////////////////////////////////////////////
// Address output register, loaded on entry to each bus step
// Loading on entry keeps the pins straight from flops
always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
        ar_q <= RST_BYTE;
    end else if ((state_d == ST_FETCH1) || (state_d == ST_B2_ADR)) begin
        ar_q <= ip_q;                               // RULE2
    end else if (state_q == ST_OPL) begin
        ar_q <= f_dir ? dr_q : sec_q;               // RULE3
    end
end

// Operand latch: second byte for direct, secondary for indirect
always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
        opl_q <= RST_BYTE;
    end else if (state_q == ST_OPL) begin
        opl_q <= f_dir ? dr_q : sec_q;              // RULE3
    end
end

// Read strobe spans both cycles of every read
always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
        memory_read_strobe_q <= 1'b0;
    end else begin
        memory_read_strobe_q <= (state_d == ST_FETCH1) || (state_d == ST_FETCH2)
                  || (state_d == ST_B2_ADR) || (state_d == ST_B2_RD)
                  || (state_d == ST_RD_ADR) || (state_d == ST_RD_DAT); // RULE3
    end
end

// Data buffer: memory sampled in the second strobe cycle
// Needs memory data only at the end of the second strobe cycle
always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
        dr_q <= RST_BYTE;
    end else if ((state_q == ST_FETCH2) || (state_q == ST_B2_RD)
                 || (state_q == ST_RD_DAT)) begin
        dr_q <= mem_rdata;                          // RULE20
    end
end

// Instruction pointer, eight bits, wraps past ffh
always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
        ip_q <= RST_BYTE;
    end else if ((state_q == ST_FETCH2) || (state_q == ST_B2_RD)) begin
        ip_q <= 8'(ip_q + IP_STEP);                 // RULE22
    end
end

// Opcode hold for the execution steps
always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
        ir_q <= RST_BYTE;
    end else if (state_q == ST_FETCH3) begin
        ir_q <= dr_q;                               // RULE1
    end
end

////////////////////////////////////////////////////////////////////
// Writeback of the final execution step
logic [7:0] alu_b;                  // OR operand
logic [7:0] alu_f;                  // OR result

// Operand B: buffer, accumulator or secondary
always_comb begin
    case (ir_q)
        OP_OR_ACC: alu_b = acc_q;                   // RULE13
        OP_OR_SEC: alu_b = sec_q;                   // RULE14
        default:   alu_b = dr_q;                    // RULE11
    endcase
    alu_f = acc_q | alu_b;                          // RULE11
end

// Accumulator
always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
        acc_q <= RST_BYTE;
    end else if (state_q == ST_EXEC) begin
        case (ir_q)
            OP_LDA_IND: acc_q <= dr_q;              // RULE4
            OP_LDA_IMM: acc_q <= dr_q;              // RULE5
            OP_OR_DIR:  acc_q <= alu_f;             // RULE12
            OP_OR_ACC:  acc_q <= alu_f;             // RULE13
            OP_OR_SEC:  acc_q <= alu_f;             // RULE14
            OP_OR_IND:  acc_q <= alu_f;             // RULE15
            OP_OR_IMM:  acc_q <= alu_f;             // RULE16
            default:    acc_q <= acc_q;             // Others leave it
        endcase
    end
end

// Secondary register
always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
        sec_q <= RST_BYTE;
    end else if (state_q == ST_EXEC) begin
        case (ir_q)
            OP_LDR_DIR: sec_q <= dr_q;              // RULE6
            OP_LDR_ACC: sec_q <= acc_q;             // RULE7
            OP_LDR_IND: sec_q <= dr_q;              // RULE9
            OP_LDR_IMM: sec_q <= dr_q;              // RULE10
            default:    sec_q <= sec_q;             // RULE8
        endcase
    end
end

////////////////////////////////////////////////////////////////////
// Port write: data loaded on setup, strobe in the middle cycle
always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
        pdata_q <= RST_BYTE;
        poe_q   <= 1'b0;
        iow_q   <= 1'b0;
    end else begin
        if (state_d == ST_WR_SET) begin
            pdata_q <= acc_q;                       // RULE17
        end
        poe_q <= (state_d == ST_WR_SET) || (state_d == ST_WR_STB)
                 || (state_d == ST_WR_HLD);         // RULE18
        iow_q <= (state_d == ST_WR_STB);            // RULE18
    end
end

// Status pulses, one cycle, during the next fetch's first cycle
always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
        done_q <= 1'b0;
        unk_q  <= 1'b0;
    end else begin
        done_q <= (state_q == ST_EXEC) || (state_q == ST_WR_HLD);
        unk_q  <= (state_q == ST_EXEC) && !f_known; // Treated as no-op
    end
end

////////////////////////////////////////////////////////////////////
// Outputs, all from flops
// Carriers assigned whole, so each has a single driver
assign mem_bus                = '{addr: ar_q, read_strobe: memory_read_strobe_q};
assign port_bus               = '{addr: ar_q, data: pdata_q, data_oe: poe_q,
                                  write_strobe: iow_q};
assign accumulator            = acc_q;
assign secondary              = sec_q;
assign instruction_pointer    = ip_q;
assign instr_done             = done_q;
assign instr_unknown          = unk_q;

////////////////////////////////////////////////////////////////////
// Checks
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!rst_n);

// Fetch lasts three cycles with the strobe on two
a_fetch_three: assert property (state_q == ST_FETCH1 |-> memory_read_strobe_q ##1 memory_read_strobe_q ##1 // RULE1
    (state_q == ST_FETCH3 && !memory_read_strobe_q))
    else $error("fetch not three cycles");

// Second byte read at pointer, pointer steps after
a_byte2_read: assert property (state_q == ST_B2_ADR |-> memory_read_strobe_q && ar_q == ip_q // RULE2
    ##1 memory_read_strobe_q ##1 ip_q == 8'($past(ip_q) + IP_STEP))
    else $error("second byte read wrong");

// Operand read holds address for two strobe cycles
a_operand_hold: assert property (state_q == ST_RD_ADR |-> memory_read_strobe_q && ar_q == opl_q // RULE3
    ##1 memory_read_strobe_q && $stable(ar_q))
    else $error("operand read not held");

// Indirect accumulator load: seven cycles, byte lands
a_lda_ind: assert property (state_q == ST_FETCH3 && dr_q == OP_LDA_IND |-> // RULE4
    ##5 state_q == ST_FETCH1 && acc_q == dr_q)
    else $error("indirect load wrong");

// Immediate loads: six cycles, pointer up by two
a_imm_load: assert property (state_q == ST_FETCH3 && (dr_q == OP_LDA_IMM || dr_q == OP_LDR_IMM) // RULE5
    |-> ##4 state_q == ST_FETCH1 && (($past(dr_q, 4) == OP_LDA_IMM) ? acc_q : sec_q) == dr_q
    && ip_q == 8'($past(ip_q, 4) + IP_STEP))
    else $error("immediate load wrong");

// Immediate secondary load leaves the accumulator alone
a_ldr_imm: assert property (state_q == ST_FETCH3 && dr_q == OP_LDR_IMM |-> // RULE10
    ##4 state_q == ST_FETCH1 && sec_q == dr_q && acc_q == $past(acc_q, 4))
    else $error("immediate secondary load wrong");

// Direct secondary load: nine cycles
a_ldr_dir: assert property (state_q == ST_FETCH3 && dr_q == OP_LDR_DIR |-> // RULE6
    ##7 state_q == ST_FETCH1 && sec_q == dr_q)
    else $error("direct secondary load wrong");

// Copy accumulator to secondary in one step
a_ldr_acc: assert property (state_q == ST_FETCH3 && dr_q == OP_LDR_ACC |-> // RULE7
    ##2 state_q == ST_FETCH1 && sec_q == acc_q)
    else $error("copy to secondary wrong");

// Self load leaves both registers alone
a_ldr_self: assert property (state_q == ST_FETCH3 && dr_q == OP_LDR_SEC |-> // RULE8
    ##2 $stable(sec_q) && sec_q == $past(sec_q, 2) && acc_q == $past(acc_q, 2))
    else $error("self load changed state");

// Indirect secondary load: seven cycles
a_ldr_ind: assert property (state_q == ST_FETCH3 && dr_q == OP_LDR_IND |-> // RULE9
    ##5 state_q == ST_FETCH1 && sec_q == dr_q)
    else $error("indirect secondary load wrong");

// Register OR forms take four cycles
a_or_reg: assert property (state_q == ST_FETCH3 && dr_q == OP_OR_SEC |-> // RULE14
    ##2 acc_q == ($past(acc_q, 2) | $past(sec_q, 2)) && state_q == ST_FETCH1)
    else $error("OR with secondary wrong");

// OR with itself keeps the accumulator value
a_or_acc: assert property (state_q == ST_FETCH3 && dr_q == OP_OR_ACC |-> // RULE13
    ##2 state_q == ST_FETCH1 && $stable(acc_q) && acc_q == $past(acc_q, 2))
    else $error("OR with accumulator wrong");

// Memory OR forms merge the buffer byte
a_or_mem: assert property (state_q == ST_FETCH3 && dr_q == OP_OR_DIR |-> // RULE12
    ##7 acc_q == ($past(acc_q, 7) | dr_q) && state_q == ST_FETCH1)
    else $error("direct OR wrong");

// Indirect OR: seven cycles, byte read at secondary
a_or_ind: assert property (state_q == ST_FETCH3 && dr_q == OP_OR_IND |-> // RULE15
    ##5 state_q == ST_FETCH1 && acc_q == ($past(acc_q, 5) | dr_q))
    else $error("indirect OR wrong");

// Immediate OR: six cycles, pointer up by two
a_or_imm: assert property (state_q == ST_FETCH3 && dr_q == OP_OR_IMM |-> // RULE16
    ##4 state_q == ST_FETCH1 && acc_q == ($past(acc_q, 4) | dr_q) && ip_q == 8'($past(ip_q, 4) + IP_STEP))
    else $error("immediate OR wrong");

// Port write: setup, strobe, hold with stable pins
a_port_write: assert property ($rose(iow_q) |-> poe_q && $stable(ar_q) && $stable(pdata_q) // RULE18
    ##1 !iow_q && poe_q && $stable(ar_q) && $stable(pdata_q))
    else $error("port write framing wrong");

// Direct port write: nine cycles
a_out_dir: assert property (state_q == ST_FETCH3 && dr_q == OP_OUT_DIR |-> // RULE17
    ##5 iow_q && pdata_q == acc_q ##2 state_q == ST_FETCH1)
    else $error("direct port write wrong");

// Indirect port write: seven cycles, address from secondary
a_out_ind: assert property (state_q == ST_FETCH3 && dr_q == OP_OUT_IND |-> // RULE19
    ##3 iow_q && ar_q == sec_q ##2 state_q == ST_FETCH1)
    else $error("indirect port write wrong");

endmodule : lpw_exec
`default_nettype wire

// ### rtl/lpw_pkg.sv
// Package: opcodes, sequencer states and bus carriers for the exec block
// Overview of operation
// RULE1: Each instruction starts with three-cycle opcode fetch
// RULE2: Second byte: address from pointer, read, increment
// RULE3: Memory operand: latch address, two-cycle read
// RULE4: 44h loads accumulator from memory at secondary
// RULE5: 46h loads accumulator with immediate byte, six
// RULE6: 48h loads secondary from direct address, nine
// RULE7: 4Ah copies accumulator into secondary, four cycles
// RULE8: 4Bh changes nothing except instruction pointer
// RULE9: 4Ch loads secondary from memory at itself
// RULE10: 4Eh loads secondary with immediate byte, six
// RULE11: OR feeds accumulator and operand, result back
// RULE12: 80h ORs direct memory byte, nine cycles
// RULE13: 82h ORs accumulator with itself, four cycles
// RULE14: 83h ORs secondary into accumulator, four cycles
// RULE15: 84h ORs memory at secondary, seven cycles
// RULE16: 86h ORs immediate byte, six cycles
// RULE17: 10h writes accumulator to direct port, nine
// RULE18: Port write: setup, strobe, hold, three cycles
// RULE19: 14h writes accumulator to port at secondary
// RULE20: Memory returns data while read strobe asserted
// RULE21: Second byte is eight-bit address or data
// RULE22: Pointer wraps modulo 256; fetch follows immediately
package lpw_pkg;

    // Opcodes handled by this block
    localparam logic [7:0] OP_LDA_IND = 8'h44;
    localparam logic [7:0] OP_LDA_IMM = 8'h46;
    localparam logic [7:0] OP_LDR_DIR = 8'h48;
    localparam logic [7:0] OP_LDR_ACC = 8'h4a;
    localparam logic [7:0] OP_LDR_SEC = 8'h4b;
    localparam logic [7:0] OP_LDR_IND = 8'h4c;
    localparam logic [7:0] OP_LDR_IMM = 8'h4e;
    localparam logic [7:0] OP_OR_DIR  = 8'h80;
    localparam logic [7:0] OP_OR_ACC  = 8'h82;
    localparam logic [7:0] OP_OR_SEC  = 8'h83;
    localparam logic [7:0] OP_OR_IND  = 8'h84;
    localparam logic [7:0] OP_OR_IMM  = 8'h86;
    localparam logic [7:0] OP_OUT_DIR = 8'h10;
    localparam logic [7:0] OP_OUT_IND = 8'h14;

    // Reset value and pointer step
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] IP_STEP  = 8'h01;

    // Sequencer steps, one per clock cycle
    typedef enum logic [3:0] {
        ST_START  = 4'b0000,
        ST_FETCH1 = 4'b0001,
        ST_FETCH2 = 4'b0010,
        ST_FETCH3 = 4'b0011,
        ST_B2_ADR = 4'b0100,
        ST_B2_RD  = 4'b0101,
        ST_OPL    = 4'b0110,
        ST_RD_ADR = 4'b0111,
        ST_RD_DAT = 4'b1000,
        ST_WR_SET = 4'b1001,
        ST_WR_STB = 4'b1010,
        ST_WR_HLD = 4'b1011,
        ST_EXEC   = 4'b1100
    } lpw_state_type;

    // Memory side of the pins
    typedef struct packed {
        logic [7:0] addr;
        logic       read_strobe;
    } lpw_mem_bus_type;

    // Port side of the pins
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic       data_oe;
        logic       write_strobe;
    } lpw_port_bus_type;

endpackage : lpw_pkg

// ### tb/lpw_far_model.sv
// Memory and I/O port model on the far side of the exec block
`timescale 1ns/10ps
`default_nettype none
module lpw_far_model
    import lpw_pkg::*;
(
    input  wire logic             sys_clk,   // Shared system clock
    input  wire lpw_mem_bus_type  mem_bus,   // Address and read strobe
    input  wire lpw_port_bus_type port_bus,  // Port pins
    output var  logic [7:0]       mem_rdata  // Memory data bus
);
    logic [7:0]       mem [256];        // Byte store, poked by the bench
    logic             phase_q = 1'b0;   // High in the second strobe cycle
    logic [7:0]       hold_q  = 8'h00;  // Last bus value
    logic [7:0]       last_rd;          // Address of the last completed read
    logic [7:0]       wr_addr;          // Port address taken at the strobe
    logic [7:0]       wr_data;          // Port data taken at the strobe
    int               wr_cnt   = 0;     // Port writes seen
    int               hold_err = 0;     // Setup or hold breaks on port pins
    logic             post_q   = 1'b0;  // Cycle after the strobe
    lpw_port_bus_type prev_q;           // Port pins one cycle back

    ////////////////////////////////////////////////////////////
    // Unwritten memory holds a harmless one-byte opcode
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'h4b;
        end
    end

    // Data only in the second strobe cycle; a moving pattern otherwise,
    // so a capture on the wrong edge cannot pass by luck
    assign mem_rdata = (mem_bus.read_strobe && phase_q) ? mem[mem_bus.addr] : ~hold_q;

    // Strobe phase and record of the read address
    always @(posedge sys_clk) begin
        hold_q  <= mem_rdata;
        phase_q <= mem_bus.read_strobe ? ~phase_q : 1'b0;
        if (mem_bus.read_strobe && phase_q) begin
            last_rd <= mem_bus.addr;
        end
    end

    ////////////////////////////////////////////////////////////
    // Port latches on the strobe; pins must stand before and after it
    always @(posedge sys_clk) begin
        prev_q <= port_bus;
        post_q <= port_bus.write_strobe;
        if (port_bus.write_strobe) begin
            wr_addr <= port_bus.addr;
            wr_data <= port_bus.data;
            wr_cnt  <= wr_cnt + 1;
            if (!prev_q.data_oe || !port_bus.data_oe || prev_q.addr != port_bus.addr
                || prev_q.data != port_bus.data) begin
                hold_err <= hold_err + 1;
            end
        end
        // Hold cycle: pins unchanged, strobe already low
        if (post_q && (port_bus.write_strobe || !port_bus.data_oe
            || prev_q.addr != port_bus.addr || prev_q.data != port_bus.data)) begin
            hold_err <= hold_err + 1;
        end
    end
endmodule : lpw_far_model
`default_nettype wire

// ### tb/load_or_port_write_exec_test.sv
// Self-checking bench for the load, OR and port-write exec block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module load_or_port_write_exec_test
    import lpw_pkg::*;
();
    logic             sys_clk     = 1'b0;   // 200 MHz
    logic             rst_n       = 1'b0;   // Sync reset, active low
    logic [7:0]       mem_rdata;            // From the memory model
    lpw_mem_bus_type  mem_bus;              // Memory pins
    lpw_port_bus_type port_bus;             // Port pins
    logic [7:0]       accumulator;          // Register views
    logic [7:0]       secondary;
    logic [7:0]       instruction_pointer;
    logic             instr_done;           // End-of-instruction pulse
    logic             instr_unknown;        // Unhandled opcode pulse
    logic [7:0]       ip_m        = 8'h00;  // Expected pointer
    int               error_cnt   = 0;      // Mismatches
    int               checks_done = 0;      // Comparisons made
    int               cycle_cnt   = 0;      // Hang guard

    lpw_exec i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .mem_rdata(mem_rdata), .mem_bus(mem_bus),
        .port_bus(port_bus), .accumulator(accumulator), .secondary(secondary),
        .instruction_pointer(instruction_pointer), .instr_done(instr_done), .instr_unknown(instr_unknown));
    lpw_far_model i_mem (.sys_clk(sys_clk), .mem_bus(mem_bus), .port_bus(port_bus), .mem_rdata(mem_rdata));

    ////////////////////////////////////////////////////////////
    // Clock and hang guard; a full run needs about 1040 cycles
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycle_cnt++;
        if (cycle_cnt == 5000) begin
            error_cnt++;
            results();
        end
    end

    // Verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////
    // Place one instruction at the pointer while its fetch is under way,
    // then count cycles to the next done pulse; data is sampled late enough
    task automatic run(input logic [7:0] b0, input logic [7:0] b1, input int nb, input int cyc,
                       input logic unk);
        int n;
        n = 0;
        i_mem.mem[ip_m] = b0;
        i_mem.mem[8'(ip_m + 8'h01)] = b1;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (instr_done !== 1'b1 && n < 40);
        ip_m = ip_m + nb[7:0];
        `CHK("cycles", cyc, n)
        `CHK("pointer", ip_m, instruction_pointer)
        `CHK("unknown", unk, instr_unknown)
    endtask : run

    ////////////////////////////////////////////////////////////
    // Register and immediate loads
    task automatic s_load_imm();
        run(8'h4b, 8'h4b, 1, 4, 1'b0);
        `CHK("acc", 8'h00, accumulator)
        `CHK("sec", 8'h00, secondary)
        run(8'h46, 8'h5a, 2, 6, 1'b0);
        `CHK("acc", 8'h5a, accumulator)
        `CHK("byte two addr", 8'(ip_m - 8'h01), i_mem.last_rd)
        run(8'h4e, 8'h10, 2, 6, 1'b0);
        `CHK("sec", 8'h10, secondary)
    endtask : s_load_imm

    // Indirect and direct memory loads, then copy
    task automatic s_load_mem();
        i_mem.mem[8'h10] = 8'hc3;
        run(8'h44, 8'h4b, 1, 7, 1'b0);
        `CHK("acc", 8'hc3, accumulator)
        `CHK("operand addr", 8'h10, i_mem.last_rd)
        i_mem.mem[8'h10] = 8'h24;
        run(8'h4c, 8'h4b, 1, 7, 1'b0);
        `CHK("sec", 8'h24, secondary)
        i_mem.mem[8'ha0] = 8'h81;
        run(8'h48, 8'ha0, 2, 9, 1'b0);
        `CHK("sec", 8'h81, secondary)
        `CHK("operand addr", 8'ha0, i_mem.last_rd)
        run(8'h4a, 8'h4b, 1, 4, 1'b0);
        `CHK("sec", 8'hc3, secondary)
    endtask : s_load_mem

    // Inclusive OR in all five modes
    task automatic s_or();
        i_mem.mem[8'hb0] = 8'h04;
        run(8'h80, 8'hb0, 2, 9, 1'b0);
        `CHK("acc", 8'hc7, accumulator)
        run(8'h82, 8'h4b, 1, 4, 1'b0);
        `CHK("acc", 8'hc7, accumulator)
        run(8'h4e, 8'hd0, 2, 6, 1'b0);
        run(8'h83, 8'h4b, 1, 4, 1'b0);
        `CHK("acc", 8'hd7, accumulator)
        i_mem.mem[8'hd0] = 8'h20;
        run(8'h84, 8'h4b, 1, 7, 1'b0);
        `CHK("acc", 8'hf7, accumulator)
        `CHK("operand addr", 8'hd0, i_mem.last_rd)
        run(8'h86, 8'h08, 2, 6, 1'b0);
        `CHK("acc", 8'hff, accumulator)
    endtask : s_or

    // Port writes, direct and indirect
    task automatic s_port();
        run(8'h46, 8'ha5, 2, 6, 1'b0);
        run(8'h10, 8'h7e, 2, 9, 1'b0);
        `CHK("port addr", 8'h7e, i_mem.wr_addr)
        `CHK("port data", 8'ha5, i_mem.wr_data)
        `CHK("port writes", 1, i_mem.wr_cnt)
        run(8'h4e, 8'h3c, 2, 6, 1'b0);
        run(8'h14, 8'h4b, 1, 7, 1'b0);
        `CHK("port addr", 8'h3c, i_mem.wr_addr)
        `CHK("port data", 8'ha5, i_mem.wr_data)
        `CHK("port writes", 2, i_mem.wr_cnt)
        `CHK("port hold", 0, i_mem.hold_err)
    endtask : s_port

    // Unhandled opcode, then pointer wrap with a split immediate
    task automatic s_wrap();
        run(8'h20, 8'h4b, 1, 4, 1'b1);
        `CHK("acc", 8'ha5, accumulator)
        while (ip_m != 8'hff) begin
            run(8'h4b, 8'h4b, 1, 4, 1'b0);
        end
        run(8'h46, 8'h6e, 2, 6, 1'b0);
        `CHK("acc", 8'h6e, accumulator)
    endtask : s_wrap

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int n;
        n = 0;
        repeat (8) @(posedge sys_clk);
        #1;
        `CHK("acc in reset", 8'h00, accumulator)
        `CHK("strobe in reset", 1'b0, mem_bus.read_strobe)
        rst_n = 1'b1;
        // First no-op at zero ends with the first done pulse
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (instr_done !== 1'b1 && n < 40);
        ip_m = 8'h01;
        `CHK("pointer", ip_m, instruction_pointer)
        s_load_imm();
        s_load_mem();
        s_or();
        s_port();
        s_wrap();
        results();
    end
endmodule : load_or_port_write_exec_test
`default_nettype wire
